//--- hw/hbis_map.vh
// Constants for the host bus interface select block.
// Assumes inclusion by hbis_core.v and hbis_buf.v only.
`ifndef HBIS_MAP_VH
`define HBIS_MAP_VH
// Strap codes
`define HBIS_STRAP_P16 4'h2
`define HBIS_STRAP_P8 4'h3
`define HBIS_STRAP_P18 4'hA
`define HBIS_STRAP_P9 4'hB
`define HBIS_STRAP_SPI_HI 3'h2
// Internal mode codes
`define HBIS_M_NONE 3'h0
`define HBIS_M_P8 3'h1
`define HBIS_M_P9 3'h2
`define HBIS_M_P16 3'h3
`define HBIS_M_P18 3'h4
`define HBIS_M_SPI 3'h5
// Pin vector layout
`define HBIS_PIN_W 28
`define HBIS_PIN_DATA_LO 0
`define HBIS_PIN_RD 18
`define HBIS_PIN_WR 19
`define HBIS_PIN_REGSEL 20
`define HBIS_PIN_CS 21
`define HBIS_PIN_ID 22
`define HBIS_PIN_STRAP_LO 23
`define HBIS_PIN_TLOW 26
`define HBIS_PIN_RSTN 27
`define HBIS_PIN_RST_VAL 28'h03FFFFF
// Serial start byte fields, last bit index and read shift MSB
`define HBIS_SB_CODE_HI 7
`define HBIS_SB_CODE_LO 3
`define HBIS_SB_ID 2
`define HBIS_SB_REGSEL 1
`define HBIS_SB_RW 0
`define HBIS_SPI_LAST_BIT 3'h7
`define HBIS_SPI_RD_MSB 15
// Serial phases
`define HBIS_PH_START 2'h0
`define HBIS_PH_DATA 2'h1
`define HBIS_PH_IGN 2'h2
`endif

//--- hw/hbis_buf.v
// Two-entry valid/ready buffer for captured host writes.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/10ps
`include "hbis_map.vh"
module hbis_buf #(
  parameter W = 19,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge ref_clk) begin
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (clk_en) begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

//--- hw/hbis_core.v
// Host bus front end: strap decode, parallel strobe bus and serial link.
// Assumes all pin inputs are asynchronous to ref_clk; the host holds
// strobes and data long enough for the three-stage filter to see them.
`timescale 1ns/10ps
`include "hbis_map.vh"
module hbis_core #(
  parameter W = 18,
  parameter [4:0] SPI_DEV_CODE = 5'h0E
) (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire reset_n_pin,
  input wire [2:0] mode_strap_pins,
  input wire mode_strap_id_pin,
  input wire tied_low_input,
  input wire cs_n,
  input wire register_select,
  input wire wr_n_scl,
  input wire rd_n,
  input wire [W-1:0] parallel_data_bus_in,
  output reg [W-1:0] parallel_data_bus_out,
  output reg [W-1:0] parallel_data_bus_oe_n,
  output reg [2:0] host_mode,
  output reg mode_forbidden,
  output reg serial_id,
  output reg dev_in_reset,
  output wire wr_valid,
  input wire wr_ready,
  output wire [W-1:0] wr_data,
  output wire wr_regsel,
  output reg wr_overrun,
  output reg rd_strobe,
  output reg rd_regsel,
  input wire [W-1:0] status_word,
  input wire [W-1:0] ctrl_word
);
  // SPI_DEV_CODE value is arbitrary.
  reg [`HBIS_PIN_W-1:0] s1_r;
  reg [`HBIS_PIN_W-1:0] s2_r;
  reg [`HBIS_PIN_W-1:0] s3_r;
  reg [`HBIS_PIN_W-1:0] f_r;
  reg [`HBIS_PIN_W-1:0] fd_r;
  wire [`HBIS_PIN_W-1:0] pins;
  wire [`HBIS_PIN_W-1:0] f_nxt;
  assign pins = {reset_n_pin, tied_low_input, mode_strap_pins, mode_strap_id_pin,
                 cs_n, register_select, wr_n_scl, rd_n, parallel_data_bus_in};

  // Each pin settles once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < `HBIS_PIN_W; gi = gi + 1) begin : g_flt
      assign f_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : f_r[gi];
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (rst) begin
      s1_r <= `HBIS_PIN_RST_VAL;
      s2_r <= `HBIS_PIN_RST_VAL;
      s3_r <= `HBIS_PIN_RST_VAL;
      f_r <= `HBIS_PIN_RST_VAL;
      fd_r <= `HBIS_PIN_RST_VAL;
    end else if (clk_en) begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= f_nxt;
      fd_r <= f_r;
    end
  end

  wire [W-1:0] f_data = f_r[`HBIS_PIN_DATA_LO +: W];
  wire f_cs_n = f_r[`HBIS_PIN_CS];
  wire f_regsel = f_r[`HBIS_PIN_REGSEL];
  wire f_rd_n = f_r[`HBIS_PIN_RD];
  wire f_rstn = f_r[`HBIS_PIN_RSTN];
  wire f_ser_in = f_r[`HBIS_PIN_DATA_LO];
  wire wr_rise = f_r[`HBIS_PIN_WR] && !fd_r[`HBIS_PIN_WR];
  wire wr_fall = !f_r[`HBIS_PIN_WR] && fd_r[`HBIS_PIN_WR];
  wire rd_fall = !f_rd_n && fd_r[`HBIS_PIN_RD];
  wire hw_rst = rst || !f_rstn;
  wire is_spi = (host_mode == `HBIS_M_SPI);
  wire is_par = !is_spi && (host_mode != `HBIS_M_NONE);
  wire sel = !f_cs_n;

  function [2:0] mode_dec;
    input [3:0] s;
    begin
      if (s[3:1] == `HBIS_STRAP_SPI_HI) begin
        mode_dec = `HBIS_M_SPI;
      end else begin
        case (s)
          `HBIS_STRAP_P16: mode_dec = `HBIS_M_P16;
          `HBIS_STRAP_P8: mode_dec = `HBIS_M_P8;
          `HBIS_STRAP_P18: mode_dec = `HBIS_M_P18;
          `HBIS_STRAP_P9: mode_dec = `HBIS_M_P9;
          default: mode_dec = `HBIS_M_NONE;
        endcase
      end
    end
  endfunction

  // Lanes to packed word, low-justified
  function [17:0] pack;
    input [2:0] m;
    input [17:0] d;
    begin
      case (m)
        `HBIS_M_P18: pack = d;
        `HBIS_M_P16: pack = {2'h0, d[17:10], d[8:1]};
        `HBIS_M_P9: pack = {9'h000, d[17:9]};
        `HBIS_M_P8: pack = {10'h000, d[17:10]};
        default: pack = 18'h00000;
      endcase
    end
  endfunction

  // Packed word to lanes, with the lanes the mode drives
  function [35:0] spread;
    input [2:0] m;
    input [17:0] w;
    begin
      case (m)
        `HBIS_M_P18: spread = {18'h3FFFF, w};
        `HBIS_M_P16: spread = {18'h3FDFE, w[15:8], 1'b0, w[7:0], 1'b0};
        `HBIS_M_P9: spread = {18'h3FE00, w[8:0], 9'h000};
        `HBIS_M_P8: spread = {18'h3FC00, w[7:0], 10'h000};
        default: spread = 36'h000000000;
      endcase
    end
  endfunction

  // Straps follow the pins while held in reset, frozen afterwards
  wire [3:0] f_straps = f_r[`HBIS_PIN_ID +: 4];
  always @(posedge ref_clk) begin
    if (rst) begin
      host_mode <= `HBIS_M_NONE;
      mode_forbidden <= 1'b1;
      serial_id <= 1'b0;
      dev_in_reset <= 1'b1;
    end else if (clk_en) begin
      dev_in_reset <= !f_rstn;
      if (!f_rstn) begin
        host_mode <= mode_dec(f_straps);
        mode_forbidden <= (mode_dec(f_straps) == `HBIS_M_NONE);
        serial_id <= f_straps[0];
      end
    end
  end

  // Capture and serial engine
  reg push_r;
  reg [W:0] push_d_r;
  reg [1:0] ph_r;
  reg [2:0] bit_r;
  reg [7:0] shin_r;
  reg spi_rw_r;
  reg spi_regsel_r;
  reg [15:0] shout_r;
  reg so_r;
  wire in_ready;
  wire [7:0] nb = {shin_r[6:0], f_ser_in};
  wire [W-1:0] rd_sel = f_regsel ? ctrl_word : status_word;
  // Serial reads pick the register from the start byte, not the pin
  wire [W-1:0] ser_sel = nb[`HBIS_SB_REGSEL] ? ctrl_word : status_word;
  wire [35:0] lanes = spread(host_mode, rd_sel);

  always @(posedge ref_clk) begin
    if (hw_rst) begin
      push_r <= 1'b0;
      push_d_r <= {(W+1){1'b0}};
      ph_r <= `HBIS_PH_START;
      bit_r <= 3'h0;
      shin_r <= 8'h00;
      spi_rw_r <= 1'b0;
      spi_regsel_r <= 1'b0;
      shout_r <= 16'h0000;
      so_r <= 1'b0;
      wr_overrun <= 1'b0;
      rd_strobe <= 1'b0;
      rd_regsel <= 1'b0;
      parallel_data_bus_out <= {W{1'b0}};
      parallel_data_bus_oe_n <= {W{1'b1}};
    end else if (clk_en) begin
      push_r <= 1'b0;
      rd_strobe <= 1'b0;
      wr_overrun <= push_r && !in_ready;
      if (is_par && sel && wr_rise) begin
        push_r <= 1'b1;
        push_d_r <= {f_regsel, pack(host_mode, f_data)};
      end
      if (is_par && sel && rd_fall) begin
        rd_strobe <= 1'b1;
        rd_regsel <= f_regsel;
      end
      if (!is_spi || !sel) begin
        ph_r <= `HBIS_PH_START;
        bit_r <= 3'h0;
        spi_rw_r <= 1'b0;
      end else if (wr_rise) begin
        shin_r <= nb;
        bit_r <= bit_r + 3'h1;
        if (bit_r == `HBIS_SPI_LAST_BIT) begin
          if (ph_r == `HBIS_PH_START) begin
            if (nb[`HBIS_SB_CODE_HI:`HBIS_SB_CODE_LO] == SPI_DEV_CODE &&
                nb[`HBIS_SB_ID] == serial_id) begin
              ph_r <= `HBIS_PH_DATA;
              spi_regsel_r <= nb[`HBIS_SB_REGSEL];
              spi_rw_r <= nb[`HBIS_SB_RW];
              shout_r <= ser_sel[15:0];
              rd_strobe <= nb[`HBIS_SB_RW];
              rd_regsel <= nb[`HBIS_SB_REGSEL];
            end else begin
              ph_r <= `HBIS_PH_IGN;
            end
          end else if (ph_r == `HBIS_PH_DATA && !spi_rw_r) begin
            push_r <= 1'b1;
            push_d_r <= {spi_regsel_r, {(W-8){1'b0}}, nb};
          end
        end
      end else if (wr_fall && ph_r == `HBIS_PH_DATA && spi_rw_r) begin
        so_r <= shout_r[`HBIS_SPI_RD_MSB];
        shout_r <= {shout_r[14:0], 1'b0};
      end
      // Output drive: low enable means the lane is driven
      if (is_par && sel && !f_rd_n) begin
        parallel_data_bus_out <= lanes[W-1:0];
        parallel_data_bus_oe_n <= ~lanes[35:18];
      end else if (is_spi && sel && ph_r == `HBIS_PH_DATA && spi_rw_r) begin
        parallel_data_bus_out <= {{(W-2){1'b0}}, so_r, 1'b0};
        parallel_data_bus_oe_n <= {{(W-2){1'b1}}, 1'b0, 1'b1};
      end else begin
        parallel_data_bus_out <= {W{1'b0}};
        parallel_data_bus_oe_n <= {W{1'b1}};
      end
    end
  end

  wire [W:0] out_d;
  hbis_buf #(.W(W+1), .DEPTH(2), .AW(1)) u_buf (
    .ref_clk(ref_clk),
    .rst(hw_rst),
    .clk_en(clk_en),
    .in_valid(push_r),
    .in_ready(in_ready),
    .in_data(push_d_r),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(out_d)
  );
  assign wr_data = out_d[W-1:0];
  assign wr_regsel = out_d[W];
endmodule

//--- hw/hbis_core_dummy_note.v
`timescale 1ns/10ps

//--- test/hbis_assertions.sv
// Checker for hbis_core port timing.
// Bound to every hbis_core; sees its ports only.
`timescale 1ns/10ps
module hbis_assertions (
  input wire ref_clk,
  input wire rst,
  input wire reset_n_pin,
  input wire [2:0] mode_strap_pins,
  input wire mode_strap_id_pin,
  input wire cs_n,
  input wire register_select,
  input wire wr_n_scl,
  input wire rd_n,
  input wire wr_ready,
  input wire [17:0] parallel_data_bus_oe_n,
  input wire [2:0] host_mode,
  input wire mode_forbidden,
  input wire dev_in_reset,
  input wire wr_valid,
  input wire [17:0] wr_data,
  input wire wr_regsel,
  input wire rd_strobe,
  input wire rd_regsel
);
  wire [3:0] s = {mode_strap_pins, mode_strap_id_pin};
  wire [2:0] exp_mode = s == 4'h2 ? 3'h3 : s == 4'h3 ? 3'h1 : s == 4'hA ? 3'h4 :
    s == 4'hB ? 3'h2 : s[3:1] == 3'h2 ? 3'h5 : 3'h0;
  wire par = host_mode != 3'h0 && host_mode != 3'h5;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  reset_state_a:
  assert property ($fell(rst) |-> dev_in_reset && mode_forbidden && host_mode == 3'h0 &&
    &parallel_data_bus_oe_n && !wr_valid) else $error("bad reset state");
  mode_decode_a:
  assert property (!dev_in_reset && !$past(dev_in_reset) |-> host_mode == exp_mode &&
    mode_forbidden == (exp_mode == 3'h0)) else $error("bad mode");
  idle_bus_a:
  assert property (cs_n [*8] |-> &parallel_data_bus_oe_n) else $error("bus driven");
  no_write_a:
  assert property ((cs_n && !wr_valid) [*8] |=> !wr_valid) else $error("stray word");
  read_drive_a:
  assert property ((!cs_n && !rd_n && par) [*8] |-> !parallel_data_bus_oe_n[17])
    else $error("read not driven");
  read_sel_a:
  assert property (rd_strobe && par |-> rd_regsel == register_select && !rd_n)
    else $error("bad read select");
  write_take_a:
  assert property ($rose(wr_n_scl) && !cs_n && par && !wr_valid |-> ##[3:8] wr_valid)
    else $error("write not taken");
  word_hold_a:
  assert property (reset_n_pin [*6] ##0 (wr_valid && !wr_ready) |=>
    wr_valid && $stable(wr_data) && $stable(wr_regsel)) else $error("word lost");
endmodule
bind hbis_core hbis_assertions u_chk (.*);

//--- test/hbis_host.sv
// Host model: strobe bus and serial master.
// Assumes ref_clk at 125 MHz; phases of 4 cycles or more.
`timescale 1ns/10ps
module hbis_host (
  input wire ref_clk,
  input wire [17:0] parallel_data_bus_in,
  output reg cs_n = 1'b1,
  output reg register_select = 1'b0,
  output reg wr_n_scl = 1'b1,
  output reg rd_n = 1'b1,
  output reg hen = 1'b1,
  output reg [17:0] hd = 18'h00000
);
  task t(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task pwr(input c, input sel_lvl, input [17:0] d);
    cs_n = c;
    register_select = sel_lvl;
    hd = d;
    t(4);
    wr_n_scl = 1'b0;
    t(6);
    wr_n_scl = 1'b1;
    t(6);
    cs_n = 1'b1;
    hd = ~d;
    t(4);
  endtask
  task prd(input sel_lvl, output [17:0] q);
    cs_n = 1'b0;
    register_select = sel_lvl;
    hen = 1'b0;
    t(4);
    rd_n = 1'b0;
    t(10);
    q = parallel_data_bus_in;
    rd_n = 1'b1;
    t(4);
    hen = 1'b1;
    cs_n = 1'b1;
    t(4);
  endtask
  // Register select and read strobe stay put
  task spi(input integer n, input [23:0] v, output [15:0] q);
    integer i;
    cs_n = 1'b0;
    t(4);
    for (i = 0; i < n; i = i + 1) begin
      wr_n_scl = 1'b0;
      hd[0] = v[23-i];
      t(4);
      wr_n_scl = 1'b1;
      t(4);
      q = {q[14:0], parallel_data_bus_in[1]};
    end
    t(4);
    cs_n = 1'b1;
    t(8);
  endtask
endmodule

//--- test/tb_top.sv
// Bench for hbis_core driven by hbis_host.
// Assumes the checker binds itself to hbis_core.
`timescale 1ns/10ps
module tb_top;
  localparam [17:0] D = 18'h3D2E7;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg clk_en = 1'b1;
  reg reset_n_pin = 1'b0;
  reg [2:0] mode_strap_pins = 3'h0;
  reg mode_strap_id_pin = 1'b0;
  reg tied_low_input = 1'b0;
  reg wr_ready = 1'b0;
  reg [17:0] status_word = 18'h2C35A;
  reg [17:0] ctrl_word = 18'h1B4E7;
  reg [17:0] q;
  wire cs_n, register_select, wr_n_scl, rd_n, hen, wr_valid, wr_regsel, wr_overrun;
  wire rd_strobe, rd_regsel, mode_forbidden, serial_id, dev_in_reset;
  wire [2:0] host_mode;
  wire [17:0] hd, parallel_data_bus_out, parallel_data_bus_oe_n, wr_data;
  wire [17:0] parallel_data_bus_in = ~parallel_data_bus_oe_n & parallel_data_bus_out |
    parallel_data_bus_oe_n & (hen ? hd : ~hd);
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer n_ovr = 0;
  hbis_core #(.SPI_DEV_CODE(5'h0E)) dut (.*);
  hbis_host u_host (.*);
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wr_overrun === 1'b1) n_ovr <= n_ovr + 1;
  task chk(input [18:0] got, input [18:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task boot(input [3:0] m);
    reset_n_pin = 1'b0;
    cyc(8);
    {mode_strap_pins, mode_strap_id_pin} = m;
    cyc(8);
    reset_n_pin = 1'b1;
    cyc(12);
  endtask
  task pop(input [18:0] e);
    integer i;
    for (i = 0; i < 20 && wr_valid !== 1'b1; i = i + 1)
      cyc(1);
    chk({wr_regsel, wr_data}, e);
    wr_ready = 1'b1;
    cyc(1);
    wr_ready = 1'b0;
    cyc(1);
  endtask
  task s_lanes;
    integer k;
    reg [3:0] m;
    reg [2:0] hm;
    reg [17:0] e;
    for (k = 0; k < 4; k = k + 1) begin
      case (k)
        0: {m, hm, e} = {4'h2, 3'h3, 2'h0, D[17:10], D[8:1]};
        1: {m, hm, e} = {4'h3, 3'h1, 10'h000, D[17:10]};
        2: {m, hm, e} = {4'hB, 3'h2, 9'h000, D[17:9]};
        default: {m, hm, e} = {4'hA, 3'h4, D};
      endcase
      boot(m);
      chk(host_mode, hm);
      u_host.pwr(1'b0, k[0], D);
      pop({k[0], e});
    end
  endtask
  task s_buf;
    u_host.pwr(1'b0, 1'b1, 18'h0A5A5);
    u_host.pwr(1'b0, 1'b0, 18'h35A5A);
    u_host.pwr(1'b0, 1'b1, 18'h3FFFF);
    cyc(8);
    chk(n_ovr[18:0], 19'h00001);
    // Clock enable low: a full buffer must not drain
    clk_en = 1'b0;
    wr_ready = 1'b1;
    cyc(4);
    chk(wr_valid, 1'b1);
    wr_ready = 1'b0;
    clk_en = 1'b1;
    pop({1'b1, 18'h0A5A5});
    pop({1'b0, 18'h35A5A});
    u_host.pwr(1'b1, 1'b0, 18'h15555);
    cyc(8);
    chk(wr_valid, 1'b0);
    u_host.prd(1'b0, q);
    chk(q, status_word);
    u_host.prd(1'b1, q);
    chk(q, ctrl_word);
  endtask
  task s_serial;
    boot(4'h5);
    chk({host_mode, serial_id}, {3'h5, 1'b1});
    u_host.spi(16, {5'h0E, 3'h6, 8'hC3, 8'h00}, q[15:0]);
    pop({1'b1, 18'h000C3});
    u_host.spi(24, {5'h0E, 3'h5, 16'h0000}, q[15:0]);
    chk(q[15:0], status_word[15:0]);
    u_host.spi(16, {5'h0E, 3'h2, 8'h5A, 8'h00}, q[15:0]);
    cyc(8);
    chk(wr_valid, 1'b0);
    boot(4'h0);
    chk({mode_forbidden, host_mode}, {1'b1, 3'h0});
    u_host.pwr(1'b0, 1'b0, 18'h12345);
    cyc(8);
    chk(wr_valid, 1'b0);
  endtask
  task complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    cyc(16);
    rst = 1'b0;
    s_lanes;
    s_buf;
    s_serial;
    complete_run;
  end
endmodule
